// ### include/mas_pkg.sv
// mas_pkg: shared constants for the metering adc serial slave port
// assumes one 20 mhz system clock; all pins arrive asynchronous to it
package mas_pkg;
  // system clock
  localparam int unsigned CLK_HZ = 20_000_000;
  // command byte layout: address in the top five bits, then read flag
  localparam int CMD_W     = 8;
  localparam int ADDR_W    = 5;
  localparam int ADDR_HI   = 7;
  localparam int ADDR_LO   = 3;
  localparam int RDEN_POS  = 2;
  localparam int WR_DATA_W = 8;
  // read words: data right aligned, length code = bytes - 1
  localparam int WORD_W  = 32;
  localparam int LEN_W   = 2;
  localparam int BUF_W   = LEN_W + WORD_W;
  localparam int BUF_DEP = 2;
  // bit counter marks, counted from zero at chip select
  localparam logic [3:0] RDEN_BIT_IDX = 4'h5;
  localparam logic [3:0] CMD_LAST_IDX = 4'h7;
  localparam logic [3:0] WR_LAST_IDX  = 4'hf;
  // filler length used when no word is ready
  localparam logic [5:0] FILL_LAST = 6'h07;
  // data ready pulse length in input clock cycles
  localparam int unsigned RDY_INPUT_CLOCK_FREQUENCY_CYC = 64;
  localparam logic [6:0]  RDY_LAST      = 7'(RDY_INPUT_CLOCK_FREQUENCY_CYC - 1);
  // reset levels
  localparam logic CS_IDLE_LVL  = 1'b1;
  localparam logic PIN_IDLE_LVL = 1'b1;
  // transfer phases
  typedef enum logic [4:0] {
    PH_IDLE  = 5'h01,
    PH_CMD   = 5'h02,
    PH_READ  = 5'h04,
    PH_WRITE = 5'h08,
    PH_DONE  = 5'h10
  } mas_phase_e;
endpackage : mas_pkg

// ### include/mas_word_if.sv
// mas_word_if: valid/ready word stream between the port's modules
// assumes both ends run on the same clock
interface mas_word_if
  import mas_pkg::*;
();
  logic             valid;  // word offered
  logic             ready;  // word taken
  logic [BUF_W-1:0] data;   // {length code, right aligned data}
  // producer end
  modport source (output valid, output data, input ready);
  // consumer end
  modport sink   (input valid, input data, output ready);
endinterface : mas_word_if

// ### hw/mas_pair_buf.sv
// mas_pair_buf: two-entry word buffer with valid/ready on both sides
// assumes flush is a level from the same clock domain
module mas_pair_buf
  import mas_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   flush,
  mas_word_if.sink    inW,
  mas_word_if.source  outW
);
  // whole buffer state
  typedef struct packed {
    logic [BUF_DEP-1:0][BUF_W-1:0] mem;  // entries
    logic                          wrPtr;
    logic                          rdPtr;
    logic [1:0]                    count;
  } mas_buf_state_s;

  mas_buf_state_s st_r;
  mas_buf_state_s st_nxt;

  // while flushing every offered word is taken and dropped
  assign inW.ready  = flush | (st_r.count != 2'(BUF_DEP));
  assign outW.valid = ~flush & (st_r.count != 2'h0);
  assign outW.data  = st_r.mem[st_r.rdPtr];

  // push and pop bookkeeping
  always_comb begin
    st_nxt = st_r;
    if (flush) begin
      st_nxt.count = 2'h0;
      st_nxt.rdPtr = 1'b0;
      st_nxt.wrPtr = 1'b0;
    end else begin
      if (inW.valid && inW.ready) begin
        st_nxt.mem[st_r.wrPtr] = inW.data;
        st_nxt.wrPtr           = ~st_r.wrPtr;
      end
      if (outW.valid && outW.ready) begin
        st_nxt.rdPtr = ~st_r.rdPtr;
      end
      // count moves only when exactly one side fires
      unique case ({inW.valid & inW.ready, outW.valid & outW.ready})
        2'b10:   st_nxt.count = st_r.count + 2'h1;
        2'b01:   st_nxt.count = st_r.count - 2'h1;
        default: st_nxt.count = st_r.count;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : mas_pair_buf

// ### hw/mas_rdy_pulse.sv
// mas_rdy_pulse: shared clock-out or data-ready pin driver
// assumes convDone is a one-cycle pulse on clk; crystal clock is a pin
module mas_rdy_pulse
  import mas_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic crystalInPin,
  input  wire logic convDone,
  input  wire logic clockOutEn,
  output logic      clockOutOrDataReadyPin
);
  // whole pulse generator state
  typedef struct packed {
    logic [1:0] xtalSync;  // [0] only feeds [1]
    logic       xtalPrev;
    logic       busy;
    logic [6:0] cnt;
    logic       pin;
  } mas_rdy_state_s;

  localparam mas_rdy_state_s RDY_RST = '{xtalSync: 2'h0, xtalPrev: 1'b0,
    busy: 1'b0, cnt: 7'h00, pin: PIN_IDLE_LVL};

  mas_rdy_state_s st_r;
  mas_rdy_state_s st_nxt;
  logic           xtalRise;

  assign xtalRise               = st_r.xtalSync[1] & ~st_r.xtalPrev;
  assign clockOutOrDataReadyPin = st_r.pin;

  // count input clock edges while the pulse is low
  always_comb begin
    st_nxt          = st_r;
    st_nxt.xtalSync = {st_r.xtalSync[0], crystalInPin};
    st_nxt.xtalPrev = st_r.xtalSync[1];
    if (convDone) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = 7'h00;
    end else if (st_r.busy && xtalRise) begin
      st_nxt.cnt = st_r.cnt + 7'h01;
      if (st_r.cnt == RDY_LAST) begin
        st_nxt.busy = 1'b0;
      end
    end
    // resampled clock costs up to a system cycle of jitter on the pin
    st_nxt.pin = clockOutEn ? st_r.xtalSync[1] : ~st_nxt.busy;
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= RDY_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : mas_rdy_pulse

// ### hw/mas_spi_slave_port.sv
// mas_spi_slave_port: serial slave port of a metering adc
// assumes sclk, csN and mosi are asynchronous pins; the core answers reads
// through a valid/ready word port and takes single-byte writes as strobes
//
// Functional notes
// - data ready pulse lasts 64 input clocks
// - mosi captured on sclk rising edges
// - miso updated on sclk falling edges
// - all words shifted most significant bit first
// - miso high impedance unless transmitting
// - chip select rise aborts, no register change
// - new command accepted once select falls
// - shared pin can carry input clock out
// - command: address 7:3, read bit 2
// - burst read streams consecutive output registers
// - write carries exactly one data byte
module mas_spi_slave_port
  import mas_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              sclkPin,
  input  wire logic              csPinN,
  input  wire logic              mosiPin,
  output logic                   misoOut,
  output logic                   misoOe,
  output logic                   rdReq,
  output logic [ADDR_W-1:0]      rdAddr,
  input  wire logic              rdValid,
  output logic                   rdReady,
  input  wire logic [WORD_W-1:0] rdData,
  input  wire logic [LEN_W-1:0]  rdLen,
  output logic                   wrStb,
  output logic [ADDR_W-1:0]      wrAddr,
  output logic [WR_DATA_W-1:0]   wrData,
  input  wire logic              crystalInPin,
  input  wire logic              convDone,
  input  wire logic              clockOutEn,
  output logic                   clockOutOrDataReadyPin
);
  // whole port state
  typedef struct packed {
    logic [1:0]           sclkSync;  // [0] only feeds [1]
    logic [1:0]           csSync;    // [0] only feeds [1]
    logic [1:0]           mosiSync;  // [0] only feeds [1]
    logic                 sclkPrev;  // for edge detection
    mas_phase_e           phase;
    logic [3:0]           bitCnt;    // bits captured this transfer
    logic [CMD_W-1:0]     shiftIn;   // incoming bits
    logic [ADDR_W-1:0]    addr;      // command address
    logic                 isRead;    // command read flag
    logic [WORD_W-1:0]    txShift;   // outgoing bits, msb at top
    logic [5:0]           txLeft;    // bits still to send of the word
    logic                 miso;
    logic                 misoOe;
    logic                 rdReq;
    logic [ADDR_W-1:0]    rdAddr;    // last requested address
    logic                 wrStb;
    logic [ADDR_W-1:0]    wrAddr;
    logic [WR_DATA_W-1:0] wrData;
  } mas_spi_state_s;

  // reset value: deselected, idle, line released
  localparam mas_spi_state_s SPI_RST = '{
    sclkSync: 2'h0,
    csSync:   {CS_IDLE_LVL, CS_IDLE_LVL},
    mosiSync: 2'h0,
    sclkPrev: 1'b0,
    phase:    PH_IDLE,
    bitCnt:   4'h0,
    shiftIn:  8'h00,
    addr:     5'h00,
    isRead:   1'b0,
    txShift:  32'h0,
    txLeft:   6'h00,
    miso:     1'b0,
    misoOe:   1'b0,
    rdReq:    1'b0,
    rdAddr:   5'h00,
    wrStb:    1'b0,
    wrAddr:   5'h00,
    wrData:   8'h00
  };

  mas_spi_state_s st_r;
  mas_spi_state_s st_nxt;

  // synchronised pin views and edges
  logic sclkRise;
  logic sclkFall;
  logic csActive;
  logic mosiBit;
  logic bufFlush;
  logic loadSlot;      // falling edge that starts a new word
  logic [WORD_W-1:0] aligned;  // popped word moved to the top

  // core to buffer, buffer to shifter
  mas_word_if coreW ();
  mas_word_if txW ();

  assign sclkRise = st_r.sclkSync[1] & ~st_r.sclkPrev;
  assign sclkFall = ~st_r.sclkSync[1] & st_r.sclkPrev;
  assign csActive = ~st_r.csSync[1];
  assign mosiBit  = st_r.mosiSync[1];

  // stale or late answers are dropped while deselected
  assign bufFlush = ~csActive;

  // core answers enter the buffer; its ready stalls the core
  assign coreW.valid = rdValid;
  assign coreW.data  = {rdLen, rdData};
  assign rdReady     = coreW.ready;

  // the shifter pops exactly when it starts a fresh word
  assign loadSlot  = (st_r.phase == PH_READ) & sclkFall & (st_r.txLeft == 6'h00);
  assign txW.ready = loadSlot;

  // two-entry buffer keeps one burst word ahead of the shifter
  mas_pair_buf u_buf (
    .clk   (clk),
    .rst   (rst),
    .flush (bufFlush),
    .inW   (coreW.sink),
    .outW  (txW.source)
  );

  // shared output pin: data ready pulse or forwarded input clock
  mas_rdy_pulse u_rdy (
    .clk                    (clk),
    .rst                    (rst),
    .crystalInPin           (crystalInPin),
    .convDone               (convDone),
    .clockOutEn             (clockOutEn),
    .clockOutOrDataReadyPin (clockOutOrDataReadyPin)
  );

  // move a right aligned word so its msb sits at the top
  always_comb begin
    unique case (txW.data[BUF_W-1 -: LEN_W])
      2'h0:    aligned = {txW.data[7:0], 24'h0};
      2'h1:    aligned = {txW.data[15:0], 16'h0};
      2'h2:    aligned = {txW.data[23:0], 8'h0};
      default: aligned = txW.data[WORD_W-1:0];
    endcase
  end

  // next state of the whole port
  always_comb begin
    st_nxt = st_r;
    // two-flop synchronisers on every pin
    st_nxt.sclkSync = {st_r.sclkSync[0], sclkPin};
    st_nxt.csSync   = {st_r.csSync[0], csPinN};
    st_nxt.mosiSync = {st_r.mosiSync[0], mosiPin};
    st_nxt.sclkPrev = st_r.sclkSync[1];
    // strobes last one cycle
    st_nxt.rdReq = 1'b0;
    st_nxt.wrStb = 1'b0;
    if (!csActive) begin
      // deselected: drop everything, release the line
      st_nxt.phase   = PH_IDLE;
      st_nxt.bitCnt  = 4'h0;
      st_nxt.shiftIn = 8'h00;
      st_nxt.isRead  = 1'b0;
      st_nxt.txLeft  = 6'h00;
      st_nxt.miso    = 1'b0;
      st_nxt.misoOe  = 1'b0;
    end else begin
      unique case (st_r.phase)
        // fresh selection always starts a new command
        PH_IDLE: begin
          st_nxt.phase = PH_CMD;
        end
        // shift in the command byte
        PH_CMD: begin
          if (sclkRise) begin
            st_nxt.shiftIn = {st_r.shiftIn[CMD_W-2:0], mosiBit};
            st_nxt.bitCnt  = st_r.bitCnt + 4'h1;
            if (st_r.bitCnt == RDEN_BIT_IDX) begin
              // address complete and read flag arriving now
              st_nxt.addr   = st_r.shiftIn[ADDR_W-1:0];
              st_nxt.isRead = mosiBit;
              // request early so the word is ready by the first output edge
              if (mosiBit) begin
                st_nxt.rdReq  = 1'b1;
                st_nxt.rdAddr = st_r.shiftIn[ADDR_W-1:0];
              end
            end
            // last two command bits are ignored
            if (st_r.bitCnt == CMD_LAST_IDX) begin
              st_nxt.phase = st_r.isRead ? PH_READ : PH_WRITE;
            end
          end
        end
        // stream words until the master deselects
        PH_READ: begin
          if (sclkFall) begin
            st_nxt.misoOe = 1'b1;
            if (loadSlot) begin
              if (txW.valid) begin
                st_nxt.miso    = aligned[WORD_W-1];
                st_nxt.txShift = {aligned[WORD_W-2:0], 1'b0};
                st_nxt.txLeft  = {1'b0, txW.data[BUF_W-1 -: LEN_W], 3'h7};
                // prefetch the next register of the burst
                st_nxt.rdReq  = 1'b1;
                st_nxt.rdAddr = st_r.rdAddr + 5'h01;
              end else begin
                // core late: send a zero byte rather than slip alignment
                st_nxt.miso    = 1'b0;
                st_nxt.txShift = 32'h0;
                st_nxt.txLeft  = FILL_LAST;
              end
            end else begin
              st_nxt.miso    = st_r.txShift[WORD_W-1];
              st_nxt.txShift = {st_r.txShift[WORD_W-2:0], 1'b0};
              st_nxt.txLeft  = st_r.txLeft - 6'h01;
            end
          end
        end
        // collect the single data byte of a write
        PH_WRITE: begin
          if (sclkRise) begin
            st_nxt.shiftIn = {st_r.shiftIn[CMD_W-2:0], mosiBit};
            st_nxt.bitCnt  = st_r.bitCnt + 4'h1;
            // only a complete byte reaches the core
            if (st_r.bitCnt == WR_LAST_IDX) begin
              st_nxt.wrStb  = 1'b1;
              st_nxt.wrAddr = st_r.addr;
              st_nxt.wrData = {st_r.shiftIn[CMD_W-2:0], mosiBit};
              st_nxt.phase  = PH_DONE;
            end
          end
        end
        // extra clocks after a write are ignored
        PH_DONE: begin
          st_nxt.phase = PH_DONE;
        end
        default: begin
          st_nxt.phase = PH_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= SPI_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign misoOut = st_r.miso;
  assign misoOe  = st_r.misoOe;
  assign rdReq   = st_r.rdReq;
  assign rdAddr  = st_r.rdAddr;
  assign wrStb   = st_r.wrStb;
  assign wrAddr  = st_r.wrAddr;
  assign wrData  = st_r.wrData;
endmodule : mas_spi_slave_port

// ### testbench/mas_spi_master_model.sv
// mas_spi_master_model: behavioural spi master facing the slave port
// assumes clk is the bench clock; sclk idles high, six clk per half period
module mas_spi_master_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      csN,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic misoOe
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins idle deselected
  initial begin
    sclk = 1'b1;
    csN  = 1'b1;
    mosi = 1'b1;
  end
  // one framed transfer of nb bits; short nb aborts mid-word
  task automatic xfer(input int nb, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    @(posedge clk) csN <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = nb - 1; i >= 0; i--) begin
      @(posedge clk) sclk <= 1'b0;
      mosi <= tx[i];
      repeat (6) @(posedge clk);
      sclk <= 1'b1;
      // undriven miso reads as unknown so it never matches
      rx[i] = (misoOe === 1'b1) ? miso : 1'bx;
      repeat (5) @(posedge clk);
    end
    @(posedge clk) csN <= 1'b1;
    mosi <= ~mosi; // released line shows no stale bit
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : mas_spi_master_model

// ### testbench/mas_spi_slave_port_monitor.sv
// mas_spi_slave_port_monitor: timing checks on the slave port pins
// assumes the bench sclk half period of six clk and a 4.096 mhz input clock
module mas_spi_slave_port_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclkPin,
  input wire logic csPinN,
  input wire logic misoOut,
  input wire logic misoOe,
  input wire logic rdReq,
  input wire logic rdReady,
  input wire logic wrStb,
  input wire logic clockOutEn,
  input wire logic clockOutOrDataReadyPin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [9:0] lowCnt; // cycles the ready pin has been low
  // low-time counter, cleared whenever the pin is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lowCnt <= '0;
    else if (clockOutOrDataReadyPin) lowCnt <= '0;
    else lowCnt <= lowCnt + 10'h001;
  end
  property p_wr_pulse; wrStb |=> !wrStb; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");
  property p_rd_pulse; rdReq |=> !rdReq; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read request longer than one cycle");
  property p_oe_idle; csPinN [*5] |-> !misoOe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
  property p_no_wr; csPinN [*5] |-> !wrStb; endproperty
  a_no_wr: assert property (p_no_wr) else $error("write strobe while deselected");
  property p_rdy_idle; csPinN [*5] |-> rdReady; endproperty
  a_rdy_idle: assert property (p_rdy_idle) else $error("word port stalled while deselected");
  property p_dr_len; $rose(clockOutOrDataReadyPin) && !clockOutEn |-> lowCnt inside {[305:320]}; endproperty
  a_dr_len: assert property (p_dr_len) else $error("data ready pulse length wrong");
  property p_oe_rise; $rose(misoOe) |-> !csPinN && $past(!csPinN, 8); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("miso enabled outside a transfer");
  property p_miso_fall; misoOe && $past(misoOe) && $changed(misoOut) |-> !$past(sclkPin, 3); endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("miso changed away from sclk fall");
endmodule : mas_spi_slave_port_monitor

bind mas_spi_slave_port mas_spi_slave_port_monitor u_mas_spi_slave_port_monitor (
  .clk, .rst, .sclkPin, .csPinN, .misoOut, .misoOe, .rdReq, .rdReady, .wrStb,
  .clockOutEn, .clockOutOrDataReadyPin
);

// ### testbench/mas_spi_slave_port_tb_top.sv
// mas_spi_slave_port_tb_top: self-checking bench of the slave port
// assumes the master model paces sclk; the bench plays the core side
module mas_spi_slave_port_tb_top;
  import mas_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, sclk, csN, mosi, miso, oe, rdReq, rdValid, rdReady, wrStb;
  logic xtal, convDone, clkOutEn, drPin, drPrev;
  logic [ADDR_W-1:0]    rdAddr, wrAddr, a;
  logic [WORD_W-1:0]    rdData;
  logic [LEN_W-1:0]     rdLen;
  logic [WR_DATA_W-1:0] wrData, d;
  logic [63:0]          rx;
  int num_errors, n_tests, seed, cyc, wrCnt, xc, tog;
  mas_spi_slave_port u_mas_spi_slave_port (
    .clk, .rst, .sclkPin(sclk), .csPinN(csN), .mosiPin(mosi), .misoOut(miso),
    .misoOe(oe), .rdReq, .rdAddr, .rdValid, .rdReady, .rdData, .rdLen, .wrStb,
    .wrAddr, .wrData, .crystalInPin(xtal), .convDone, .clockOutEn(clkOutEn),
    .clockOutOrDataReadyPin(drPin)
  );
  mas_spi_master_model u_mas_spi_master_model (
    .clk, .sclk, .csN, .mosi, .miso, .misoOe(oe)
  );
  // register contents as the core would return them, right aligned
  function automatic logic [WORD_W-1:0] wf(input logic [ADDR_W-1:0] x);
    return {8'h00, 3'h5, x, 8'ha5 ^ {3'h0, x}, 3'h2, x};
  endfunction : wf
  // first 48 bits of a burst from ra; each word is (low address bits + 1) bytes
  function automatic logic [47:0] bs(input logic [ADDR_W-1:0] ra);
    logic [47:0]       r;
    logic [WORD_W-1:0] w;
    logic [4:0]        x;
    int                p;
    r = '0;
    x = ra;
    p = 47;
    while (p >= 0) begin
      w = wf(x);
      for (int b = 8 * int'(x[1:0]) + 7; b >= 0 && p >= 0; b--) begin
        r[p] = w[b];
        p--;
      end
      x = x + 5'h01;
    end
    return r;
  endfunction : bs
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // free-running input clock near 4.096 mhz, unrelated to clk
  initial begin
    xtal = 1'b0;
    forever #122 xtal = ~xtal;
  end
  // core side: answer each request promptly, hold until taken
  always @(posedge clk) begin
    if (rdReq) begin
      rdValid <= 1'b1;
      rdData  <= wf(rdAddr);
      rdLen   <= rdAddr[1:0]; // length follows the address so every code is used
    end else if (rdValid && rdReady) rdValid <= 1'b0;
  end
  // observers: write strobes, input clock edges in the pulse, pin toggles
  always @(posedge clk) begin
    if (wrStb === 1'b1) wrCnt++;
    if (clkOutEn && drPin !== drPrev) tog++;
    drPrev <= drPin;
    cyc++;
    if (cyc == 50000) begin
      num_errors++;
      stop_test();
    end
  end
  always @(posedge xtal) if (drPin === 1'b0 && !clkOutEn) xc++;
  // one write: command with read bit clear, then one byte
  task automatic do_wr(input logic [4:0] wa, input logic [7:0] wd, input int nb);
    int c0;
    c0 = wrCnt;
    u_mas_spi_master_model.xfer(nb, 64'({wa, 1'b0, 2'h3, wd}) >> (16 - nb), rx);
    check("write count", wrCnt - c0, (nb == 16) ? 1 : 0);
    if (nb == 16) check("write addr", wrAddr, wa);
    if (nb == 16) check("write data", wrData, wd);
  endtask : do_wr
  // burst read of 48 bits, spanning two or more words
  task automatic do_rd(input logic [4:0] ra);
    logic [47:0] e;
    e = bs(ra);
    u_mas_spi_master_model.xfer(56, {8'h00, ra, 1'b1, 2'h1, 48'h0}, rx);
    check("burst bits 47:24", rx[47:24], e[47:24]);
    check("burst bits 23:0", rx[23:0], e[23:0]);
  endtask : do_rd
  initial begin
    seed = 42;
    rst = 1'b1;
    rdValid = 1'b0;
    rdData = '0;
    rdLen = '0;
    convDone = 1'b0;
    clkOutEn = 1'b0;
    drPrev = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // settle time stands in for polling the reset flag
    repeat (4) @(posedge clk);
    // corner addresses, then random ones
    do_rd(5'h00);
    do_rd(5'h1f);
    do_wr(5'h1f, 8'h80, 16);
    do_wr(5'h05, 8'h3c, 12);
    do_wr(5'h06, 8'h01, 16);
    for (int k = 0; k < 4; k++) begin
      a = 5'($random(seed));
      d = 8'($random(seed));
      do_wr(a, d, 16);
      do_rd(a);
    end
    check("oe idle", oe, 1'b0);
    // data ready pulse, then clock forwarding
    xc = 0;
    @(posedge clk) convDone <= 1'b1;
    @(posedge clk) convDone <= 1'b0;
    repeat (2) @(posedge clk);
    check("ready low", drPin, 1'b0);
    repeat (340) @(posedge clk);
    check("ready high", drPin, 1'b1);
    // a rise just before the pulse starts is counted by the design but not here
    check("ready edges", (xc >= 63 && xc <= 64), 1);
    tog = 0;
    clkOutEn <= 1'b1;
    repeat (200) @(posedge clk);
    check("clock out", (tog > 60), 1);
    stop_test();
  end
endmodule : mas_spi_slave_port_tb_top
